// file: adc_cfg.svh
// Offsets, field positions, reset values and timing counts for the converter link.
// Included by the package users; holds definitions only.
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH

// Command byte layout
`define CMD_CONV_BIT     7
`define CMD_MC_BIT       6
`define CMD_PTR_MSB      5
`define CMD_PTR_LSB      3
`define CMD_CC_MSB       2
`define CMD_CC_LSB       0
`define CC_CONVERT       3'h0
`define SYNC1_BYTE       8'hff
`define SYNC0_BYTE       8'hfe
`define EXIT_BYTE        8'hff

// Serial frame lengths in serial clocks
`define CMD_BITS         6'h08
`define FLAG_BITS        6'h08
`define DATA_BITS        6'h20
`define READ_BITS        6'h28

// Setup word layout: two setups per word, upper half first
`define SETUP_W          16
`define SETUP_CHAN_MSB   15
`define SETUP_CHAN_LSB   14
`define SETUP_UNI_BIT    6
`define SETUP_RESET      32'h0000_0000

// Result word layout and code limits
`define RES_CODE_MSB     31
`define RES_CODE_LSB     8
`define RES_OF_BIT       2
`define UNI_MAX          24'hffffff
`define UNI_MIN          24'h000000
`define BI_MAX           24'h7fffff
`define BI_MIN           24'h800000

// Controller register map
`define HOST_OP_OFS      32'h0000_0000
`define HOST_STATUS_OFS  32'h0000_0004
`define HOST_RESULT_OFS  32'h0000_0008
`define OP_READ_BIT      8
`define ST_BUSY_BIT      0
`define ST_READY_BIT     1

// Serial clock timing
`define SCLK_HALF_NS     60
`define SYS_CLK_MHZ      200

`endif

// file: adc_device.sv
// What this block does
// - Pointer bits pick one of eight setups
// - Byte 10000000 runs one conversion, setup 1
// - Byte 11010000 starts continuous conversions, setup 3
// - Byte 10011001 runs self offset calibration
// - Forty clocks read result, then command mode unless still continuous
// - Data out falls when calibration ends
// - Continuous mode: read and stay, leave, skip
// - Unwritten setups all convert channel one
// - Flush filter on first conversion or channel change
// - Start timing fixed after synchronised command
// - Host watches one device, reads all
// - 32-bit word, MSB first, code in 31:8
// - Bits 7 to 3 read zero
// - Bit 2 flags input beyond span
// - Bits 1:0 give converted channel
// - Unipolar plain binary, bipolar two's complement
// - Codes saturate at the documented limits
// - Span zero..full scale or minus..plus
// - Host holds data in low first eight
// - All ones in flag byte ends continuous
//
// Converter end: serial port on the link, setup words and the analogue
// conversion engine on the user side. Link pins arrive asynchronously.
//
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "adc_cfg.svh"
module adc_device #(
  parameter int RAW_W = 26
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  adc_link_if.device            link,
  input  wire logic             setup_wr,
  input  wire logic [1:0]       setup_idx,
  input  wire logic [31:0]      setup_wdata,
  output logic                  conv_req_ff,
  output logic                  conv_flush_ff,
  output logic      [1:0]       conv_chan_ff,
  output logic                  conv_bipolar_ff,
  input  wire logic             conv_done,
  input  wire logic [RAW_W-1:0] conv_raw,
  output logic                  cal_req_ff,
  output logic      [2:0]       cal_type_ff,
  input  wire logic             cal_done,
  output logic                  cont_mode_ff
);
  adc_pkg::dev_state_t state_ff;
  logic [31:0] setup_ff [4];
  logic [2:0]  sclk_sh_ff;
  logic [1:0]  sdi_sh_ff;
  logic [1:0]  csn_sh_ff;
  logic        sdo_ff;
  logic [7:0]  byte_ff;
  logic [5:0]  cnt_ff;
  logic [31:0] shift_ff;
  logic [1:0]  last_chan_ff;
  logic        chan_known_ff;
  logic [31:0] result_word;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        sdi_s;
  logic [7:0]  byte_in;
  logic [2:0]  ptr;
  logic [15:0] setup_sel;
  logic [1:0]  sel_chan;
  logic        start_conv;
  logic        start_cal;
  logic        again;

  // Two stages before any logic looks at the pins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sh_ff <= 3'h0;
      sdi_sh_ff  <= 2'h0;
      csn_sh_ff  <= 2'h3;
    end else begin
      sclk_sh_ff <= {sclk_sh_ff[1:0], link.sclk};
      sdi_sh_ff  <= {sdi_sh_ff[0], link.serial_data_in};
      csn_sh_ff  <= {csn_sh_ff[0], link.cs_n};
    end
  end

  // Deselected device ignores the shared clock
  assign sclk_rise = ~csn_sh_ff[1] & sclk_sh_ff[1] & ~sclk_sh_ff[2];
  assign sclk_fall = ~csn_sh_ff[1] & ~sclk_sh_ff[1] & sclk_sh_ff[2];
  assign sdi_s     = sdi_sh_ff[1];
  assign byte_in   = {byte_ff[6:0], sdi_s};

  // Setup words keep reset contents until written
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        setup_ff[i] <= `SETUP_RESET;
      end
    end else if (setup_wr) begin
      setup_ff[setup_idx] <= setup_wdata;
    end
  end

  assign ptr       = byte_in[`CMD_PTR_MSB:`CMD_PTR_LSB];
  assign setup_sel = ptr[0] ? setup_ff[ptr[2:1]][`SETUP_W-1:0]
                            : setup_ff[ptr[2:1]][31:`SETUP_W];
  assign sel_chan  = setup_sel[`SETUP_CHAN_MSB:`SETUP_CHAN_LSB];

  // Decode happens on the eighth synchronised rise, a fixed number of
  // clocks after the pin edge, so grouped devices start together
  assign start_conv = state_ff == adc_pkg::DEV_CMD && sclk_rise
                    && cnt_ff == `CMD_BITS - 6'h01
                    && byte_in[`CMD_CONV_BIT]
                    && byte_in[`CMD_CC_MSB:`CMD_CC_LSB] == `CC_CONVERT
                    && byte_in != `SYNC0_BYTE;
  assign start_cal  = state_ff == adc_pkg::DEV_CMD && sclk_rise
                    && cnt_ff == `CMD_BITS - 6'h01
                    && byte_in[`CMD_CONV_BIT]
                    && byte_in[`CMD_CC_MSB:`CMD_CC_LSB] != `CC_CONVERT
                    && byte_in != `SYNC1_BYTE
                    && byte_in != `SYNC0_BYTE;

  // Continuous mode asks for the next sample as soon as one lands
  assign again = cont_mode_ff & conv_done;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_req_ff     <= 1'b0;
      conv_flush_ff   <= 1'b0;
      conv_chan_ff    <= 2'h0;
      conv_bipolar_ff <= 1'b0;
    end else if (start_conv) begin
      conv_req_ff     <= 1'b1;
      conv_chan_ff    <= sel_chan;
      conv_bipolar_ff <= ~setup_sel[`SETUP_UNI_BIT];
      conv_flush_ff   <= ~chan_known_ff | (sel_chan != last_chan_ff);
    end else if (again) begin
      conv_req_ff     <= 1'b1;
      conv_flush_ff   <= 1'b0;
    end else begin
      conv_req_ff     <= 1'b0;
      conv_flush_ff   <= 1'b0;
    end
  end

  // Last converted channel decides whether the filter must restart
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_chan_ff  <= 2'h0;
      chan_known_ff <= 1'b0;
    end else if (conv_req_ff) begin
      last_chan_ff  <= conv_chan_ff;
      chan_known_ff <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_req_ff  <= 1'b0;
      cal_type_ff <= 3'h0;
    end else begin
      cal_req_ff <= start_cal;
      if (start_cal) begin
        cal_type_ff <= byte_in[`CMD_CC_MSB:`CMD_CC_LSB];
      end
    end
  end

  result_formatter #(
    .RAW_W (RAW_W)
  ) u_fmt (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .load    (conv_done),
    .raw     (conv_raw),
    .bipolar (conv_bipolar_ff),
    .chan    (conv_chan_ff),
    .word_ff (result_word)
  );

  // Serial port sequencing
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff     <= adc_pkg::DEV_CMD;
      sdo_ff       <= 1'b1;
      byte_ff      <= 8'h00;
      cnt_ff       <= 6'h00;
      shift_ff     <= 32'h0000_0000;
      cont_mode_ff <= 1'b0;
    end else begin
      case (state_ff)
        adc_pkg::DEV_CMD: begin
          if (sclk_rise) begin
            sdo_ff  <= 1'b1;
            byte_ff <= byte_in;
            cnt_ff  <= cnt_ff + 6'h01;
            if (cnt_ff == `CMD_BITS - 6'h01) begin
              cnt_ff <= 6'h00;
              if (start_conv) begin
                cont_mode_ff <= byte_in[`CMD_MC_BIT];
                state_ff     <= adc_pkg::DEV_CONV;
              end else if (start_cal) begin
                state_ff <= adc_pkg::DEV_CAL;
              end
            end
          end
        end
        adc_pkg::DEV_CONV: begin
          if (conv_done) begin
            sdo_ff   <= 1'b0;
            state_ff <= adc_pkg::DEV_READY;
          end
        end
        adc_pkg::DEV_READY: begin
          if (sclk_rise) begin
            sdo_ff   <= 1'b1;
            byte_ff  <= byte_in;
            cnt_ff   <= 6'h01;
            state_ff <= adc_pkg::DEV_CLEAR;
          end else begin
            // Unread word replaced: flag blinks high for one cycle
            sdo_ff <= conv_done;
          end
        end
        adc_pkg::DEV_CLEAR: begin
          if (sclk_rise) begin
            byte_ff <= byte_in;
            cnt_ff  <= cnt_ff + 6'h01;
            if (cnt_ff == `FLAG_BITS - 6'h01) begin
              cnt_ff   <= 6'h00;
              shift_ff <= result_word;
              state_ff <= adc_pkg::DEV_SHIFT;
              if (byte_in == `EXIT_BYTE) begin
                cont_mode_ff <= 1'b0;
              end
            end
          end
        end
        adc_pkg::DEV_SHIFT: begin
          if (sclk_fall) begin
            sdo_ff   <= shift_ff[31];
            shift_ff <= {shift_ff[30:0], 1'b0};
          end
          if (sclk_rise) begin
            cnt_ff <= cnt_ff + 6'h01;
            if (cnt_ff == `DATA_BITS - 6'h01) begin
              cnt_ff   <= 6'h00;
              sdo_ff   <= 1'b1;
              state_ff <= cont_mode_ff ? adc_pkg::DEV_CONV
                                       : adc_pkg::DEV_CMD;
            end
          end
        end
        adc_pkg::DEV_CAL: begin
          if (cal_done) begin
            sdo_ff   <= 1'b0;
            state_ff <= adc_pkg::DEV_CMD;
          end
        end
        default: begin
          state_ff <= adc_pkg::DEV_CMD;
        end
      endcase
    end
  end

  assign link.serial_data_out = sdo_ff;
endmodule : adc_device

// file: adc_host.sv
// Controller end: AHB-Lite slave registers on one side, serial link on the
// other. Drives the serial clock from a divider; one converter attached.
`timescale 1ns/1ps
`include "adc_cfg.svh"
module adc_host (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  adc_link_if.host         link
);
  localparam int HALF_CYC = (`SCLK_HALF_NS * `SYS_CLK_MHZ + 999) / 1000;

  adc_pkg::host_state_t state_ff;
  logic        wr_pend_ff;
  logic [31:0] waddr_ff;
  logic [31:0] rdata_ff;
  logic [7:0]  div_ff;
  logic [5:0]  bits_ff;
  logic [5:0]  total_ff;
  logic [39:0] tx_ff;
  logic [31:0] rx_ff;
  logic [31:0] result_ff;
  logic [1:0]  sdo_sh_ff;
  logic        sclk_ff;
  logic        sdi_ff;
  logic        csn_ff;
  logic        tick;
  logic        addr_ok;
  logic        start_op;
  logic        busy;

  assign addr_ok  = hsel & hready & htrans[1];
  assign busy     = state_ff != adc_pkg::H_IDLE;
  assign start_op = wr_pend_ff && waddr_ff == `HOST_OP_OFS && !busy;
  assign tick     = div_ff == 8'(HALF_CYC - 1);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo_sh_ff <= 2'h3;
    end else begin
      sdo_sh_ff <= {sdo_sh_ff[0], link.serial_data_out};
    end
  end

  // Bus slave: zero wait states, read data prepared in the address phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_ff <= 1'b0;
      waddr_ff   <= 32'h0000_0000;
      rdata_ff   <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= addr_ok & hwrite;
      if (addr_ok) begin
        waddr_ff <= haddr;
      end
      if (addr_ok && !hwrite) begin
        case (haddr)
          `HOST_STATUS_OFS: rdata_ff <= {30'h0, ~sdo_sh_ff[1], busy};
          `HOST_RESULT_OFS: rdata_ff <= result_ff;
          default:          rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hrdata    = rdata_ff;
  assign hresp     = 1'b0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 8'h00;
    end else if (!busy || tick) begin
      div_ff <= 8'h00;
    end else begin
      div_ff <= div_ff + 8'h01;
    end
  end

  // Command: eight bits; read: flag byte (zeros, or all ones to leave
  // continuous mode) then 32 result bits
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff  <= adc_pkg::H_IDLE;
      bits_ff   <= 6'h00;
      total_ff  <= 6'h00;
      tx_ff     <= 40'h00_0000_0000;
      rx_ff     <= 32'h0000_0000;
      result_ff <= 32'h0000_0000;
      sclk_ff   <= 1'b0;
      sdi_ff    <= 1'b0;
      csn_ff    <= 1'b1;
    end else begin
      case (state_ff)
        adc_pkg::H_IDLE: begin
          if (start_op) begin
            csn_ff   <= 1'b0;
            tx_ff    <= {hwdata[7:0], 32'h0000_0000};
            sdi_ff   <= hwdata[7];
            bits_ff  <= 6'h00;
            total_ff <= hwdata[`OP_READ_BIT] ? `READ_BITS : `CMD_BITS;
            state_ff <= adc_pkg::H_LOW;
          end
        end
        adc_pkg::H_LOW: begin
          if (tick) begin
            sclk_ff  <= 1'b1;
            rx_ff    <= {rx_ff[30:0], sdo_sh_ff[1]};
            bits_ff  <= bits_ff + 6'h01;
            tx_ff    <= {tx_ff[38:0], 1'b0};
            state_ff <= adc_pkg::H_HIGH;
          end
        end
        adc_pkg::H_HIGH: begin
          if (tick) begin
            sclk_ff <= 1'b0;
            sdi_ff  <= tx_ff[39];
            if (bits_ff == total_ff) begin
              if (total_ff == `READ_BITS) begin
                result_ff <= rx_ff;
              end
              state_ff <= adc_pkg::H_IDLE;
            end else begin
              state_ff <= adc_pkg::H_LOW;
            end
          end
        end
        default: begin
          state_ff <= adc_pkg::H_IDLE;
        end
      endcase
    end
  end

  assign link.sclk = sclk_ff;
  assign link.serial_data_in  = sdi_ff;
  assign link.cs_n = csn_ff;
endmodule : adc_host

// file: adc_link_assertions.sv
// Checker for the converter link and the converter's request pulses.
// Instantiated by testbench beside the link interface; one clock domain.
`timescale 1ns/1ps
module adc_link_assertions (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       sclk,
  input wire logic       serial_data_in,
  input wire logic       cs_n,
  input wire logic       serial_data_out,
  input wire logic       conv_req_ff,
  input wire logic       conv_flush_ff,
  input wire logic [1:0] conv_chan_ff,
  input wire logic       conv_done,
  input wire logic       cal_req_ff,
  input wire logic       cal_done,
  input wire logic       cont_mode_ff
);
  logic       pend_ff;
  logic       cal_pend_ff;
  logic       hold_ff;
  logic       seen_ff;
  logic [1:0] last_ch_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Single conversions only; continuous ones re-arm by themselves
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) pend_ff <= 1'b0;
    else if (conv_req_ff && !cont_mode_ff) pend_ff <= 1'b1;
    else if (conv_done || cont_mode_ff) pend_ff <= 1'b0;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) cal_pend_ff <= 1'b0;
    else if (cal_req_ff) cal_pend_ff <= 1'b1;
    else if (cal_done) cal_pend_ff <= 1'b0;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) hold_ff <= 1'b0;
    else if ((pend_ff && conv_done) || (cal_pend_ff && cal_done)) hold_ff <= 1'b1;
    else if (sclk) hold_ff <= 1'b0;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_ff    <= 1'b0;
      last_ch_ff <= 2'h0;
    end else if (conv_req_ff) begin
      seen_ff    <= 1'b1;
      last_ch_ff <= conv_chan_ff;
    end
  end

  chk_conv_ready_flag: assert property (pend_ff && conv_done |=> !serial_data_out)
    else $error("ready flag missing after single conversion");
  chk_cal_ready_flag: assert property (cal_pend_ff && cal_done |=> !serial_data_out)
    else $error("ready flag missing after calibration");
  chk_flag_holds_low: assert property (hold_ff && !sclk |-> !serial_data_out)
    else $error("ready flag released before read");
  chk_sclk_idle_desel: assert property (cs_n |-> !sclk)
    else $error("serial clock active while deselected");
  chk_sclk_high_span: assert property ($rose(sclk) |-> ##11 sclk ##1 !sclk)
    else $error("serial clock high phase wrong length");
  chk_sdi_low_phase: assert property ($changed(serial_data_in) |-> !sclk)
    else $error("data in changed while clock high");
  chk_flush_on_change: assert property (conv_req_ff |->
      conv_flush_ff == (!seen_ff || conv_chan_ff != last_ch_ff))
    else $error("filter flush does not follow channel change");
  chk_cont_reissue: assert property (cont_mode_ff && conv_done |=>
      conv_req_ff && !conv_flush_ff)
    else $error("continuous mode did not restart conversion");

  cover property ($fell(serial_data_out));
  cover property (conv_req_ff && conv_flush_ff);
  cover property (cal_req_ff);
  cover property ($fell(cont_mode_ff));
endmodule : adc_link_assertions

// file: adc_link_if.sv
// Three-wire serial link plus chip select between controller and converter.
// The bench joins both modports; no clocking here.
`timescale 1ns/1ps
interface adc_link_if;
  logic sclk;
  logic serial_data_in;
  logic cs_n;
  logic serial_data_out;

  modport device (
    input  sclk,
    input  serial_data_in,
    input  cs_n,
    output serial_data_out
  );

  modport host (
    output sclk,
    output serial_data_in,
    output cs_n,
    input  serial_data_out
  );
endinterface : adc_link_if

// file: adc_pkg.sv
// Types shared by both ends of the converter serial link.
// Constants live in adc_cfg.svh.
package adc_pkg;

  typedef enum logic [2:0] {
    DEV_CMD   = 3'b000,
    DEV_CONV  = 3'b001,
    DEV_READY = 3'b010,
    DEV_CLEAR = 3'b011,
    DEV_SHIFT = 3'b100,
    DEV_CAL   = 3'b101
  } dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_LOW  = 2'b01,
    H_HIGH = 2'b10
  } host_state_t;

endpackage : adc_pkg

// file: result_formatter.sv
// Clamps a raw sample to a 24-bit code and packs the 32-bit result word.
// Assumes raw is a signed count in code units with headroom above 24 bits.
`timescale 1ns/1ps
`include "adc_cfg.svh"
module result_formatter #(
  parameter int RAW_W = 26
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic [RAW_W-1:0] raw,
  input  wire logic             bipolar,
  input  wire logic [1:0]       chan,
  output logic      [31:0]      word_ff
);
  logic signed [RAW_W-1:0] s_raw;
  logic        [23:0]      code;
  logic                    over;

  assign s_raw = raw;

  always_comb begin
    code = s_raw[23:0];
    over = 1'b0;
    if (bipolar) begin
      if (s_raw > $signed({{(RAW_W-24){1'b0}}, `BI_MAX})) begin
        code = `BI_MAX;
        over = 1'b1;
      end else if (s_raw < -$signed({{(RAW_W-24){1'b0}}, `BI_MIN})) begin
        code = `BI_MIN;
        over = 1'b1;
      end
    end else begin
      if (s_raw > $signed({{(RAW_W-24){1'b0}}, `UNI_MAX})) begin
        code = `UNI_MAX;
        over = 1'b1;
      end else if (s_raw < 0) begin
        code = `UNI_MIN;
        over = 1'b1;
      end
    end
  end

  // Code, flag and channel land together so one word tells one sample
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_ff <= 32'h0000_0000;
    end else if (load) begin
      word_ff <= {code, 5'h00, over, chan};
    end
  end
endmodule : result_formatter

// file: testbench.sv
// Self-checking bench: AHB-Lite master on the controller, converter user side
// modelled here; both link ends joined through adc_link_if.
`timescale 1ns/1ps
`include "adc_cfg.svh"
module testbench;
  logic               sys_clk;
  logic               rst_n;
  logic               hsel;
  logic        [31:0] haddr;
  logic        [1:0]  htrans;
  logic               hwrite;
  logic        [2:0]  hsize;
  logic        [31:0] hwdata;
  logic               hreadyout;
  logic        [31:0] hrdata;
  logic               hresp;
  logic               setup_wr;
  logic        [1:0]  setup_idx;
  logic        [31:0] setup_wdata;
  logic               conv_req_ff;
  logic               conv_flush_ff;
  logic        [1:0]  conv_chan_ff;
  logic               conv_bipolar_ff;
  logic               conv_done;
  logic        [25:0] conv_raw;
  logic               cal_req_ff;
  logic        [2:0]  cal_type_ff;
  logic               cal_done;
  logic               cont_mode_ff;
  int                 n_errors;
  int                 checks_done;
  int unsigned        n_req;
  int unsigned        n_cal;
  logic        [1:0]  got_ch;
  logic               got_flush;
  logic               got_bip;
  logic        [2:0]  got_cal;

  adc_link_if link ();
  adc_host u_adc_host (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(link.host));
  adc_device #(.RAW_W(26)) u_adc_device (.sys_clk(sys_clk), .rst_n(rst_n),
    .link(link.device), .setup_wr(setup_wr), .setup_idx(setup_idx),
    .setup_wdata(setup_wdata), .conv_req_ff(conv_req_ff), .conv_flush_ff(conv_flush_ff),
    .conv_chan_ff(conv_chan_ff), .conv_bipolar_ff(conv_bipolar_ff), .conv_done(conv_done),
    .conv_raw(conv_raw), .cal_req_ff(cal_req_ff), .cal_type_ff(cal_type_ff),
    .cal_done(cal_done), .cont_mode_ff(cont_mode_ff));
  adc_link_assertions u_adc_link_assertions (.sys_clk(sys_clk), .rst_n(rst_n),
    .sclk(link.sclk), .serial_data_in(link.serial_data_in), .cs_n(link.cs_n), .serial_data_out(link.serial_data_out),
    .conv_req_ff(conv_req_ff), .conv_flush_ff(conv_flush_ff), .conv_chan_ff(conv_chan_ff),
    .conv_done(conv_done), .cal_req_ff(cal_req_ff), .cal_done(cal_done),
    .cont_mode_ff(cont_mode_ff));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Request pulses last one cycle; command ones fire while an op is still busy, continuous re-requests after conv_done
  always @(negedge sys_clk) begin
    if (conv_req_ff === 1'b1) begin
      n_req     = n_req + 1;
      got_ch    = conv_chan_ff;
      got_flush = conv_flush_ff;
      got_bip   = conv_bipolar_ff;
    end
    if (cal_req_ff === 1'b1) begin
      n_cal   = n_cal + 1;
      got_cal = cal_type_ff;
    end
  end

  task automatic print_verdict();
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    q = hrdata;
  endtask : ahb

  task automatic poll(input int bit_no, input logic e, input int lim);
    logic [31:0] q;
    int          n;
    n = 0;
    do begin
      ahb(1'b0, `HOST_STATUS_OFS, 32'h0, q);
      n = n + 1;
    end while (q[bit_no] !== e && n < lim);
    chk(32'(q[bit_no]), 32'(e));
  endtask : poll

  task automatic op(input logic rd, input logic [7:0] b);
    logic [31:0] q;
    ahb(1'b1, `HOST_OP_OFS, {23'h0, rd, b}, q);
    poll(`ST_BUSY_BIT, 1'b0, 4000);
  endtask : op

  task automatic rd_res(input logic [31:0] exp);
    logic [31:0] q;
    op(1'b1, 8'h00);
    ahb(1'b0, `HOST_RESULT_OFS, 32'h0, q);
    chk(q, exp);
  endtask : rd_res

  task automatic fire(input logic [25:0] r);
    @(posedge sys_clk);
    conv_raw  <= r;
    conv_done <= 1'b1;
    @(posedge sys_clk);
    conv_done <= 1'b0;
    poll(`ST_READY_BIT, 1'b1, 40);
  endtask : fire

  function automatic logic [31:0] word_of(input logic signed [25:0] r, input logic bip,
                                          input logic [1:0] ch);
    logic [23:0] c;
    logic        of;
    c  = r[23:0];
    of = 1'b1;
    if (bip && r > 26'sh07fffff) c = 24'h7fffff;
    else if (bip && r < -26'sh0800000) c = 24'h800000;
    else if (!bip && r > 26'sh0ffffff) c = 24'hffffff;
    else if (!bip && r < 0) c = 24'h000000;
    else of = 1'b0;
    return {c, 5'h00, of, ch};
  endfunction : word_of

  logic [1:0]  ch_tab [8] = '{2'h3, 2'h0, 2'h0, 2'h1, 2'h3, 2'h2, 2'h3, 2'h3};
  logic [25:0] corner [4] = '{26'h0800000, 26'h3ffffff, 26'h1000000, 26'h37fffff};
  logic [7:0]  u;
  logic [25:0] raw;
  logic [1:0]  prev;
  logic [31:0] q;
  int unsigned r;

  initial begin
    {rst_n, hsel, haddr, htrans, hwrite, hwdata, setup_wr, setup_idx} = '0;
    {setup_wdata, conv_done, conv_raw, cal_done} = '0;
    {n_errors, checks_done, n_req, n_cal} = '0;
    hsize = 3'h2;
    r = $urandom(32'h12ef);
    u = 8'($urandom);
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk(32'(hresp), 32'h0);
    ahb(1'b1, 32'h0000_0010, 32'($urandom), q);
    ahb(1'b0, 32'h0000_0010, 32'h0, q);
    chk(q, 32'h0);
    // Port-reset bytes and bytes without the command bit start nothing
    r = n_req + n_cal;
    op(1'b0, `SYNC1_BYTE);
    op(1'b0, `SYNC0_BYTE);
    op(1'b0, 8'h58);
    chk(n_req + n_cal - r, 32'h0);
    r = n_req;
    op(1'b0, 8'h80);
    chk({8'(n_req - r), got_ch, got_bip, got_flush}, {8'h1, 2'h0, 1'b1, 1'b1});
    raw = 26'($urandom);
    fire(raw);
    rd_res(word_of(raw, 1'b1, 2'h0));
    poll(`ST_READY_BIT, 1'b0, 2);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      setup_wr    <= 1'b1;
      setup_idx   <= 2'(i);
      setup_wdata <= {ch_tab[2*i], 7'h0, u[2*i], 6'h0, ch_tab[2*i+1], 7'h0, u[2*i+1], 6'h0};
    end
    @(posedge sys_clk);
    setup_wr <= 1'b0;
    prev = 2'h0;
    for (int i = 0; i < 8; i++) begin
      r = n_req;
      op(1'b0, {2'b10, 3'(i), 3'b000});
      chk({8'(n_req - r), got_ch, got_bip, got_flush},
          {8'h1, ch_tab[i], ~u[i], ch_tab[i] != prev});
      prev = ch_tab[i];
      raw  = (i < 4) ? corner[i] : 26'($urandom);
      fire(raw);
      rd_res(word_of(raw, ~u[i], ch_tab[i]));
    end
    r = n_cal;
    op(1'b0, 8'h99);
    chk({8'(n_cal - r), got_cal}, {8'h1, 3'h1});
    @(posedge sys_clk);
    cal_done <= 1'b1;
    @(posedge sys_clk);
    cal_done <= 1'b0;
    poll(`ST_READY_BIT, 1'b1, 40);
    r = n_req;
    op(1'b0, 8'hd0);
    chk({8'(n_req - r), cont_mode_ff, got_ch, got_flush}, {8'h1, 1'b1, 2'h0, 1'b1});
    poll(`ST_READY_BIT, 1'b0, 2);
    raw = 26'($urandom);
    fire(raw);
    rd_res(word_of(raw, ~u[2], 2'h0));
    chk(32'(cont_mode_ff), 32'h1);
    fire(26'($urandom));
    raw = corner[1];
    r   = n_req;
    fire(raw);
    chk({8'(n_req - r), got_flush}, {8'h1, 1'b0});
    ahb(1'b1, `HOST_OP_OFS, 32'h0000_01ff, q);
    poll(`ST_BUSY_BIT, 1'b0, 4000);
    ahb(1'b0, `HOST_RESULT_OFS, 32'h0, q);
    chk(q, word_of(raw, ~u[2], 2'h0));
    chk(32'(cont_mode_ff), 32'h0);
    print_verdict();
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors = n_errors + 1;
    print_verdict();
  end
endmodule : testbench
